/* File: hw/nfca_regs.sv */
// Our own choice: register access over APB.
`timescale 1ns/1ps
module nfca_regs
  import nfca_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input nfca_rx_evt_t rx_evt,
  input wire logic [3:0] listen_state,
  input wire logic short_cmd_req,
  input wire logic tx_start,
  input wire logic [7:0] tx_byte,
  input wire logic tx_byte_valid,
  output logic tx_byte_ready,
  output nfca_tx_bit_t tx_bit,
  output logic hard_framing_error_irq,
  output logic parity_error_irq
);

  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  function automatic logic [2:0] nfca_decode(input logic [11:0] addr);
    logic [2:0] sel;
    sel = 3'h7;
    unique case (addr)
      ADDR_COLL: sel = 3'h0;
      ADDR_LISTEN: sel = 3'h1;
      ADDR_TXLEN_HI: sel = 3'h2;
      ADDR_TXLEN_LO: sel = 3'h3;
      ADDR_CTRL: sel = 3'h4;
      ADDR_STAT: sel = 3'h5;
      default: sel = 3'h7;
    endcase
    return sel;
  endfunction

  // Byte-wide registers share one read layout
  function automatic logic [31:0] nfca_word8(input logic [7:0] val);
    return {24'h0, val};
  endfunction

  logic [7:0] txlen_hi;
  logic [7:0] txlen_lo;
  logic [1:0] ctrl;
  logic [7:0] coll_reg;
  logic fields_invalid;
  logic pend_valid;
  logic [3:0] pend_byte;
  logic [2:0] pend_bit;
  logic pend_pb;
  logic pend_ferr;
  logic tx_busy;
  logic [31:0] next_prdata;

  wire [2:0] reg_sel = nfca_decode(paddr);
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr_en = access && pwrite && pready;
  wire mapped = (reg_sel != 3'h7);

  wire anctl = ctrl[CTRL_ANCTL_POS];
  wire acmode = ctrl[CTRL_ACMODE_POS];
  // High byte holds the most significant part of the count
  wire [4:0] tx_count_lo = txlen_lo[7:NTX_LO_LSB];
  wire [12:0] tx_count = {txlen_hi, tx_count_lo};
  wire [2:0] tx_extra = txlen_lo[NTX_LO_LSB-1:0];

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Zero wait states: read data is captured in setup
  assign pready = 1'b1;

  // ---------------------------------------------------------------
  // Register select
  // ---------------------------------------------------------------
  // One hit line per register keeps read mux and write strobes aligned
  wire hit_coll = (reg_sel == 3'h0);
  wire hit_listen = (reg_sel == 3'h1);
  wire hit_txlen_hi = (reg_sel == 3'h2);
  wire hit_txlen_lo = (reg_sel == 3'h3);
  wire hit_ctrl = (reg_sel == 3'h4);
  wire hit_stat = (reg_sel == 3'h5);

  // ---------------------------------------------------------------
  // Read words
  // ---------------------------------------------------------------
  // Unused upper bits of every word read as zero
  wire [31:0] word_coll = nfca_word8(coll_reg);
  wire [31:0] word_listen = {28'h0, listen_state};
  wire [31:0] word_txlen_hi = nfca_word8(txlen_hi);
  wire [31:0] word_txlen_lo = nfca_word8(txlen_lo);
  wire [31:0] word_ctrl = {30'h0, ctrl};
  wire [31:0] word_stat = {30'h0, tx_busy, fields_invalid};

  // Unmapped addresses read zero
  assign next_prdata = hit_coll ? word_coll :
                       hit_listen ? word_listen :
                       hit_txlen_hi ? word_txlen_hi :
                       hit_txlen_lo ? word_txlen_lo :
                       hit_ctrl ? word_ctrl :
                       hit_stat ? word_stat :
                       32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= !mapped;
    end
  end

  // ---------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------
  // Writes to read-only addresses are ignored but not flagged
  wire wr_txlen_hi = wr_en && hit_txlen_hi;
  wire wr_txlen_lo = wr_en && hit_txlen_lo;
  wire wr_ctrl = wr_en && hit_ctrl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txlen_hi <= RST_TXLEN_HI;
    end else if (wr_txlen_hi) begin
      txlen_hi <= pwdata[7:0];
    end
  end

  // Low byte also carries the extra-bit field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txlen_lo <= RST_TXLEN_LO;
    end else if (wr_txlen_lo) begin
      txlen_lo <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Collision capture
  // ---------------------------------------------------------------
  // First collision of the frame is held until the frame ends
  wire rx_end = rx_evt.frame_end;
  wire rx_coll = rx_evt.collision;
  wire rx_ferr = rx_evt.framing_err;
  wire first_coll = rx_coll && !pend_valid;
  wire capture = first_coll && !rx_end;
  wire commit = rx_end && rx_evt.anticoll;
  wire any_coll = pend_valid || rx_coll;
  wire [3:0] use_byte = pend_valid ? pend_byte : rx_evt.coll_byte;
  wire [2:0] use_bit = pend_valid ? pend_bit : rx_evt.coll_bit;
  wire use_pb = pend_valid ? pend_pb : rx_evt.coll_in_parity;
  wire frame_ferr = pend_ferr || rx_ferr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_valid <= 1'b0;
    end else if (rx_end) begin
      pend_valid <= 1'b0;
    end else if (first_coll) begin
      pend_valid <= 1'b1;
    end
  end

  // Later collisions of the same frame must not move the position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_byte <= 4'h0;
      pend_bit <= 3'h0;
      pend_pb <= 1'b0;
    end else if (capture) begin
      pend_byte <= rx_evt.coll_byte;
      pend_bit <= rx_evt.coll_bit;
      pend_pb <= rx_evt.coll_in_parity;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ferr <= 1'b0;
    end else if (rx_end) begin
      pend_ferr <= 1'b0;
    end else if (rx_ferr) begin
      pend_ferr <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Collision commit
  // ---------------------------------------------------------------
  // An anticollision frame with no collision commits all-zero fields
  wire [3:0] next_coll_byte = any_coll ? use_byte : 4'h0;
  wire [2:0] next_coll_bit = any_coll ? use_bit : 3'h0;
  wire next_coll_pb = any_coll && use_pb;

  // One write of all three fields keeps host reads coherent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coll_reg <= RST_COLL;
    end else if (commit) begin
      coll_reg[7:COLL_BYTE_LSB] <= next_coll_byte;
      coll_reg[COLL_BYTE_LSB-1:COLL_BIT_LSB] <= next_coll_bit;
      coll_reg[COLL_PB_POS] <= next_coll_pb;
    end
  end

  // ---------------------------------------------------------------
  // Invalid marker
  // ---------------------------------------------------------------
  // Set wins: an error in the committing cycle still marks the fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fields_invalid <= 1'b0;
    end else if (rx_ferr || commit) begin
      fields_invalid <= frame_ferr;
    end
  end

  // ---------------------------------------------------------------
  // Event outputs
  // ---------------------------------------------------------------
  wire card_idle = (listen_state == NFCA_IDLE);
  wire split_set = (tx_extra != 3'h0);
  wire short_bad = short_cmd_req && anctl && card_idle && split_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hard_framing_error_irq <= 1'b0;
    end else begin
      hard_framing_error_irq <= rx_ferr;
    end
  end

  // ---------------------------------------------------------------
  // Parity error event
  // ---------------------------------------------------------------
  // Pulse only: the short command itself is not held back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_error_irq <= 1'b0;
    end else begin
      parity_error_irq <= short_bad;
    end
  end

  // ---------------------------------------------------------------
  // Transmit length and serializer
  // ---------------------------------------------------------------
  // Full bytes lose parity only in anticollision mode with a split last byte
  wire tx_no_par = acmode && (tx_extra != 3'h0);

  nfca_tx_serializer u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .start(tx_start),
    .byte_count(tx_count),
    .extra_bits(tx_extra),
    .no_parity(tx_no_par),
    .in_data(tx_byte),
    .in_valid(tx_byte_valid),
    .in_ready(tx_byte_ready),
    .bit_out(tx_bit),
    .busy(tx_busy)
  );

endmodule

/* File: hw/nfca_pkg.sv */
package nfca_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_COLL = 8'h20;
  localparam logic [7:0] IDX_LISTEN = 8'h21;
  localparam logic [7:0] IDX_TXLEN_HI = 8'h22;
  localparam logic [7:0] IDX_TXLEN_LO = 8'h23;
  localparam logic [7:0] IDX_CTRL = 8'h30;
  localparam logic [7:0] IDX_STAT = 8'h31;

  localparam logic [11:0] ADDR_COLL = {2'b00, IDX_COLL, 2'b00};
  localparam logic [11:0] ADDR_LISTEN = {2'b00, IDX_LISTEN, 2'b00};
  localparam logic [11:0] ADDR_TXLEN_HI = {2'b00, IDX_TXLEN_HI, 2'b00};
  localparam logic [11:0] ADDR_TXLEN_LO = {2'b00, IDX_TXLEN_LO, 2'b00};
  localparam logic [11:0] ADDR_CTRL = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_STAT = {2'b00, IDX_STAT, 2'b00};

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int COLL_BYTE_LSB = 4;
  localparam int COLL_BIT_LSB = 1;
  localparam int COLL_PB_POS = 0;
  localparam int NTX_LO_LSB = 3;
  localparam int CTRL_ANCTL_POS = 0;
  localparam int CTRL_ACMODE_POS = 1;
  localparam int STAT_INVALID_POS = 0;
  localparam int STAT_TXBUSY_POS = 1;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_TXLEN_HI = 8'h00;
  localparam logic [7:0] RST_TXLEN_LO = 8'h00;
  localparam logic [7:0] RST_COLL = 8'h00;
  localparam logic [1:0] RST_CTRL = 2'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int TX_BIT_NS = 9440;
  localparam int TX_BIT_CYC = TX_BIT_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    NFCA_POWER_OFF = 4'h0,
    NFCA_IDLE = 4'h1,
    NFCA_READY_L1 = 4'h2,
    NFCA_READY_L2 = 4'h3,
    NFCA_ACTIVE = 4'h5,
    NFCA_HALT = 4'h9,
    NFCA_READY_L1S = 4'ha,
    NFCA_READY_L2S = 4'hb,
    NFCA_ACTIVES = 4'hd
  } nfca_listen_t;

  typedef struct packed {
    logic frame_end;
    logic anticoll;
    logic collision;
    logic [3:0] coll_byte;
    logic [2:0] coll_bit;
    logic coll_in_parity;
    logic framing_err;
  } nfca_rx_evt_t;

  typedef struct packed {
    logic valid;
    logic data;
    logic is_parity;
    logic last;
  } nfca_tx_bit_t;

endpackage

/* File: hw/nfca_tx_serializer.sv */
`timescale 1ns/1ps
module nfca_tx_serializer
  import nfca_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [12:0] byte_count,
  input wire logic [2:0] extra_bits,
  input wire logic no_parity,
  input wire logic [7:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output nfca_tx_bit_t bit_out,
  output logic busy
);

  typedef enum logic [1:0] {
    NFCA_TX_IDLE = 2'b00,
    NFCA_TX_LOAD = 2'b01,
    NFCA_TX_DATA = 2'b11,
    NFCA_TX_PAR = 2'b10
  } nfca_tx_state_t;

  localparam logic [9:0] TICK_LAST = 10'(TX_BIT_CYC - 1);

  nfca_tx_state_t state;
  logic [9:0] tick_cnt;
  logic [12:0] bytes_left;
  logic [7:0] shreg;
  logic [3:0] bits_left;
  logic partial;
  logic par_acc;

  // ---------------------------------------------------------------
  // Bit clock enable
  // ---------------------------------------------------------------
  wire bit_tick = (tick_cnt == TICK_LAST);
  wire in_bits = (state == NFCA_TX_DATA) || (state == NFCA_TX_PAR);
  wire [12:0] bytes_after = bytes_left - 13'h0001;
  wire more_after = (bytes_after != 13'h0000) || (extra_bits != 3'h0);
  wire last_data = (bits_left == 4'h1);
  wire start_ok = start && ((byte_count != 13'h0000) || (extra_bits != 3'h0));
  wire tx_last = (state == NFCA_TX_PAR && !more_after) ||
                 (state == NFCA_TX_DATA && last_data &&
                  (partial || (no_parity && !more_after)));

  assign in_ready = (state == NFCA_TX_LOAD);
  assign busy = (state != NFCA_TX_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 10'h000;
    end else if (!in_bits || bit_tick) begin
      tick_cnt <= 10'h000;
    end else begin
      tick_cnt <= tick_cnt + 10'h001;
    end
  end

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= NFCA_TX_IDLE;
      bytes_left <= 13'h0000;
      shreg <= 8'h00;
      bits_left <= 4'h0;
      partial <= 1'b0;
      par_acc <= 1'b1;
    end else begin
      unique case (state)
        NFCA_TX_IDLE: begin
          if (start_ok) begin
            bytes_left <= byte_count;
            state <= NFCA_TX_LOAD;
          end
        end
        NFCA_TX_LOAD: begin
          if (in_valid) begin
            shreg <= in_data;
            par_acc <= 1'b1;
            // Trailing partial byte uses only its low bits
            partial <= (bytes_left == 13'h0000);
            bits_left <= (bytes_left == 13'h0000) ? {1'b0, extra_bits} : 4'h8;
            state <= NFCA_TX_DATA;
          end
        end
        NFCA_TX_DATA: begin
          if (bit_tick) begin
            shreg <= {1'b0, shreg[7:1]};
            par_acc <= par_acc ^ shreg[0];
            bits_left <= bits_left - 4'h1;
            if (last_data) begin
              if (partial) begin
                state <= NFCA_TX_IDLE;
              end else if (no_parity) begin
                bytes_left <= bytes_after;
                state <= more_after ? NFCA_TX_LOAD : NFCA_TX_IDLE;
              end else begin
                state <= NFCA_TX_PAR;
              end
            end
          end
        end
        NFCA_TX_PAR: begin
          if (bit_tick) begin
            bytes_left <= bytes_after;
            state <= more_after ? NFCA_TX_LOAD : NFCA_TX_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registered bit output
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_out <= '0;
    end else begin
      bit_out.valid <= in_bits && bit_tick;
      bit_out.data <= (state == NFCA_TX_PAR) ? par_acc : shreg[0];
      bit_out.is_parity <= (state == NFCA_TX_PAR);
      bit_out.last <= in_bits && bit_tick && tx_last;
    end
  end

endmodule

/* File: tb/nfca_regs_chk.sv */
`timescale 1ns/1ps
module nfca_regs_chk
  import nfca_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input nfca_rx_evt_t rx_evt,
  input wire logic [3:0] listen_state,
  input wire logic short_cmd_req,
  input nfca_tx_bit_t tx_bit,
  input wire logic hard_framing_error_irq,
  input wire logic parity_error_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // Shadow of the writable registers
  // ----
  logic [7:0] hi_sh;
  logic [7:0] lo_sh;
  logic [1:0] ctl_sh;
  wire wr_acc = psel && penable && pwrite && pready;
  wire rd_set = psel && !penable && !pwrite;
  wire mapped = paddr inside {ADDR_COLL, ADDR_LISTEN, ADDR_TXLEN_HI, ADDR_TXLEN_LO,
                              ADDR_CTRL, ADDR_STAT};
  wire par_ok = short_cmd_req && listen_state == 4'h1 && ctl_sh[0] && lo_sh[2:0] != 3'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_sh <= RST_TXLEN_HI;
      lo_sh <= RST_TXLEN_LO;
      ctl_sh <= RST_CTRL;
    end else if (wr_acc) begin
      if (paddr == ADDR_TXLEN_HI) hi_sh <= pwdata[7:0];
      if (paddr == ADDR_TXLEN_LO) lo_sh <= pwdata[7:0];
      if (paddr == ADDR_CTRL) ctl_sh <= pwdata[1:0];
    end
  end
  // ----
  // Properties
  // ----
  a_ready_no_wait: assert property (psel && !penable |=> pready && pslverr == !$past(mapped))
    else $error("access answer wrong");
  a_hard_irq_raise: assert property (rx_evt.framing_err |=> hard_framing_error_irq)
    else $error("hard irq missing");
  a_hard_irq_cause: assert property (hard_framing_error_irq |-> $past(rx_evt.framing_err))
    else $error("hard irq spurious");
  a_par_irq_raise: assert property (par_ok |=> parity_error_irq)
    else $error("parity irq missing");
  a_par_irq_cause: assert property (parity_error_irq |-> $past(par_ok))
    else $error("parity irq spurious");
  a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no slave error");
  a_listen_view: assert property (rd_set && paddr == ADDR_LISTEN |=>
    prdata == {28'h0, $past(listen_state)}) else $error("listen view wrong");
  a_txlen_view: assert property (rd_set && paddr == ADDR_TXLEN_HI |=>
    prdata == {24'h0, hi_sh}) else $error("tx length wrong");
  a_split_no_par: assert property (tx_bit.valid && ctl_sh[1] && lo_sh[2:0] != 3'h0
    |-> !tx_bit.is_parity) else $error("parity in split frame");
endmodule

/* File: tb/nfca_byte_src.sv */
`timescale 1ns/1ps
module nfca_byte_src
  import nfca_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] delay,
  input wire logic [7:0] byte_in,
  input wire logic tx_byte_ready,
  output logic [7:0] tx_byte,
  output logic tx_byte_valid
);
  logic [2:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_byte_valid <= 1'b0;
      tx_byte <= 8'h00;
      cnt <= 3'h0;
    end else if (tx_byte_valid && tx_byte_ready) begin
      // Scramble after release so a stale fetch cannot pass
      tx_byte_valid <= 1'b0;
      tx_byte <= ~tx_byte;
      cnt <= 3'h0;
    end else if (tx_byte_ready && !tx_byte_valid) begin
      if (cnt == delay) begin
        tx_byte_valid <= 1'b1;
        tx_byte <= byte_in;
      end else cnt <= cnt + 3'h1;
    end
  end
endmodule

/* File: tb/nfca_regs_tb.sv */
`timescale 1ns/1ps
module nfca_regs_tb
  import nfca_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, short_req = 1'b0, tx_start = 1'b0, byte_vld, byte_rdy, herr, perr;
  nfca_rx_evt_t rx_evt = '0;
  nfca_tx_bit_t tx_bit;
  logic [3:0] listen = 4'h0;
  logic [7:0] tx_byte, src_byte = 8'h00, coll_exp = 8'h00;
  logic [2:0] src_delay = 3'h0;
  logic [32:0] apb_e;
  logic [32:0] apb_q[$];
  logic [2:0] tx_q[$];
  logic [1:0] irq_q[$];
  logic [3:0] codes[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h9, 4'ha, 4'hb, 4'hd};
  logic [7:0] pcase[5] = '{8'ha1, 8'h21, 8'h81, 8'hf2, 8'h91};
  int err_total = 0;
  int checks_done = 0;
  always #10 pclk = ~pclk;
  nfca_regs i_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_evt(rx_evt), .listen_state(listen), .short_cmd_req(short_req),
    .tx_start(tx_start), .tx_byte(tx_byte), .tx_byte_valid(byte_vld),
    .tx_byte_ready(byte_rdy), .tx_bit(tx_bit), .hard_framing_error_irq(herr),
    .parity_error_irq(perr));
  nfca_byte_src i_src(.pclk(pclk), .presetn(presetn), .delay(src_delay), .byte_in(src_byte),
    .tx_byte_ready(byte_rdy), .tx_byte(tx_byte), .tx_byte_valid(byte_vld));
  // ----
  // Checking and ending
  // ----
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic stop_test;
    if (apb_q.size() + tx_q.size() + irq_q.size() != 0) err_total++;
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic hang;
    $display("ERROR wait expected done seen timeout");
    err_total++;
    stop_test();
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      apb_e = apb_q.pop_front();
      if (pwrite) chk("pslverr", {apb_e[32], 32'h0}, {pslverr, 32'h0});
      else chk("read", apb_e, {pslverr, prdata});
    end
    if (tx_bit.valid === 1'b1) begin
      if (tx_q.size() == 0) chk("tx extra", 33'h0, 33'h1);
      else chk("tx bit", tx_q.pop_front(), {tx_bit.data, tx_bit.is_parity, tx_bit.last});
    end
    if (herr === 1'b1 || perr === 1'b1) begin
      if (irq_q.size() == 0) chk("irq extra", 33'h0, {herr, perr});
      else chk("irq", irq_q.pop_front(), {herr, perr});
    end
  end
  // ----
  // Bus and traffic tasks
  // ----
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [32:0] e);
    int n;
    apb_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) hang();
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00, {25'h0, e});
  endtask
  task automatic rx_frame(input logic ac, input logic co, input logic [7:0] f);
    @(posedge pclk);
    rx_evt <= {2'h0, co, f, 1'b0};
    @(posedge pclk);
    rx_evt <= {2'h0, co, ~f, 1'b0};
    @(posedge pclk);
    rx_evt <= {1'b1, ac, 10'h000};
    @(posedge pclk);
    rx_evt <= '0;
    if (ac) coll_exp = co ? f : 8'h00;
  endtask
  task automatic tx_frame(input logic md, input logic [2:0] ex, input logic [12:0] cnt);
    logic [7:0] b;
    int n;
    b = 8'($urandom);
    wr(ADDR_CTRL, {6'h00, md, 1'b0});
    wr(ADDR_TXLEN_HI, cnt[12:5]);
    wr(ADDR_TXLEN_LO, {cnt[4:0], ex});
    src_byte <= b;
    src_delay <= 3'($urandom_range(7, 0));
    for (int i = 0; i < cnt; i++) begin
      for (int k = 0; k < 8; k++) tx_q.push_back({b[k], 2'h0});
      if (!(md && ex != 3'h0)) tx_q.push_back({~^b, 2'h2});
    end
    for (int k = 0; k < ex; k++) tx_q.push_back({b[k], 2'h0});
    tx_q[tx_q.size() - 1][0] = 1'b1;
    @(posedge pclk);
    tx_start <= 1'b1;
    @(posedge pclk);
    tx_start <= 1'b0;
    // Restart while busy must be ignored
    repeat (600) @(posedge pclk);
    tx_start <= 1'b1;
    @(posedge pclk);
    tx_start <= 1'b0;
    rd(ADDR_STAT, 8'h02);
    n = 0;
    while (tx_q.size() != 0) begin
      @(posedge pclk);
      n++;
      if (n > 20000) hang();
    end
    repeat (600) @(posedge pclk);
    rd(ADDR_STAT, 8'h00);
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    logic [31:0] v;
    logic [7:0] c;
    void'($urandom(63));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_COLL, RST_COLL);
    rd(ADDR_TXLEN_HI, RST_TXLEN_HI);
    rd(ADDR_TXLEN_LO, RST_TXLEN_LO);
    rd(ADDR_CTRL, {6'h00, RST_CTRL});
    wr(ADDR_COLL, 8'hff);
    rd(ADDR_COLL, RST_COLL);
    apb(1'b1, 12'h090, 8'h5a, {1'b1, 32'h0});
    apb(1'b0, 12'h3fc, 8'h00, {1'b1, 32'h0});
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 32'hffff_ffff : $urandom;
      wr(ADDR_TXLEN_HI, v[7:0]);
      wr(ADDR_TXLEN_LO, v[15:8]);
      rd(ADDR_TXLEN_HI, v[7:0]);
      rd(ADDR_TXLEN_LO, v[15:8]);
    end
    foreach (codes[k]) begin
      listen <= codes[k];
      wr(ADDR_LISTEN, 8'hff);
      rd(ADDR_LISTEN, {4'h0, codes[k]});
    end
    for (int i = 0; i < 12; i++) begin
      v = $urandom;
      rx_frame(i % 3 != 2, i % 4 != 3, v[7:0]);
      rd(ADDR_COLL, coll_exp);
    end
    irq_q.push_back(2'h2);
    @(posedge pclk);
    rx_evt <= 12'h001;
    @(posedge pclk);
    rx_evt <= '0;
    rd(ADDR_STAT, 8'h01);
    rx_frame(1'b1, 1'b1, 8'h5b);
    rd(ADDR_STAT, 8'h01);
    rx_frame(1'b1, 1'b0, 8'h00);
    rd(ADDR_STAT, 8'h00);
    rd(ADDR_COLL, 8'h00);
    foreach (pcase[k]) begin
      c = pcase[k];
      wr(ADDR_CTRL, {7'h00, c[7]});
      wr(ADDR_TXLEN_LO, {5'h00, c[6:4]});
      listen <= c[3:0];
      if (c[7] && c[6:4] != 3'h0 && c[3:0] == 4'h1) irq_q.push_back(2'h1);
      @(posedge pclk);
      short_req <= 1'b1;
      @(posedge pclk);
      short_req <= 1'b0;
    end
    tx_frame(1'b0, 3'h3, 13'h0001);
    tx_frame(1'b1, 3'h5, 13'h0001);
    tx_frame(1'b1, 3'h0, 13'h0002);
    repeat (20) @(posedge pclk);
    stop_test();
  end
endmodule
bind nfca_regs nfca_regs_chk i_chk(.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_evt(rx_evt), .listen_state(listen_state),
  .short_cmd_req(short_cmd_req), .tx_bit(tx_bit),
  .hard_framing_error_irq(hard_framing_error_irq), .parity_error_irq(parity_error_irq));
